// ### dv/vdt_display.sv
`default_nettype none
module vdt_display (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic line_end,
    input wire logic vsync_o,
    input wire logic vblank_o,
    output logic [7:0] sync_lines,
    output logic [7:0] blank_lines
);
    timeunit 1ns;
    timeprecision 1ps;
    logic vs_q;
    logic vb_q;
    // Lines seen inside each pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vs_q <= 1'b0;
            vb_q <= 1'b0;
            sync_lines <= 8'h00;
            blank_lines <= 8'h00;
        end else begin
            vs_q <= vsync_o;
            vb_q <= vblank_o;
            if (vsync_o && !vs_q) sync_lines <= 8'h00;
            else if (line_end && vsync_o) sync_lines <= sync_lines + 8'h01;
            if (vblank_o && !vb_q) blank_lines <= 8'h00;
            else if (line_end && vblank_o) blank_lines <= blank_lines + 8'h01;
        end
    end
endmodule // vdt_display
`default_nettype wire

// ### dv/vdt_top_asserts.sv
`default_nettype none
module vdt_top_asserts
    import vdt_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic line_end,
    input wire logic half_line,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic vblank_o,
    input wire logic vsync_o,
    input wire logic field_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready stood too long");
    a_rd_mapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_TOTAL_ACTIVE
        |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == RESP_OKAY)) else $error("mapped read refused");
    a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 16'h8000
        |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0))
        else $error("unmapped read accepted");
    a_vsync_step: assert property ($changed(vsync_o) |-> $past(line_end) || $past(half_line))
        else $error("vsync moved without a step");
    a_vblank_step: assert property ($changed(vblank_o) |-> $past(line_end) || $past(half_line))
        else $error("vblank moved without a step");
    a_field_step: assert property ($changed(field_o) |-> $past(line_end) || $past(half_line))
        else $error("field moved without a step");
    c_vsync: cover property ($rose(vsync_o));
    c_field: cover property ($rose(field_o));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule // vdt_top_asserts
`default_nettype wire

// ### dv/vdt_top_tb.sv
`default_nettype none
module vdt_top_tb import vdt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OFS = (10 - 6) / 2;
    logic clk = 1'b0, arst_n = 1'b0, line_end = 1'b0, half_line = 1'b0;
    logic [15:0] aw_a = 16'h0000, ar_a = 16'h0000;
    logic [31:0] w_d = 32'h0, r_d, rd;
    logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
    logic aw_r, w_r, b_v, ar_r, r_v, vblank, vsync, field, act;
    logic [1:0] b_rs, r_rs, rsp;
    logic [7:0] sync_lines, blank_lines;
    int n_fail = 0, check_count = 0, n;
    always #10 clk = ~clk;
    vdt_top dut_u (.clk(clk), .arst_n(arst_n), .line_end(line_end), .half_line(half_line),
        .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_rs), .s_axi_bvalid(b_v),
        .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
        .s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
        .vblank_o(vblank), .vsync_o(vsync), .field_o(field), .display_active_o(act));
    vdt_display mon_u (.clk(clk), .arst_n(arst_n), .line_end(line_end), .vsync_o(vsync), .vblank_o(vblank),
        .sync_lines(sync_lines), .blank_lines(blank_lines));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hang();
        chk("timeout", 32'h0, 32'h1);
        stop_test();
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ad = 1'b0, wd = 1'b0;
        int i = 0;
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        while (!(ad && wd)) begin
            if (++i > 50) hang();
            @(posedge clk);
            if (aw_v && aw_r) ad = 1'b1;
            if (w_v && w_r) wd = 1'b1;
            if (ad) aw_v <= 1'b0;
            if (wd) w_v <= 1'b0;
        end
        do begin
            if (++i > 100) hang();
            @(posedge clk);
        end while (!b_v);
        // Late ready so the response must be held
        b_r <= 1'b1;
        do begin
            if (++i > 100) hang();
            @(posedge clk);
        end while (!b_v);
        r = b_rs;
        b_r <= 1'b0;
    endtask
    task automatic rdr(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        int i = 0;
        ar_a <= a;
        ar_v <= 1'b1;
        do begin
            if (++i > 50) hang();
            @(posedge clk);
        end while (!ar_r);
        ar_v <= 1'b0;
        do begin
            if (++i > 100) hang();
            @(posedge clk);
        end while (!r_v);
        r_r <= 1'b1;
        do begin
            if (++i > 100) hang();
            @(posedge clk);
        end while (!r_v);
        d = r_d;
        r = r_rs;
        r_r <= 1'b0;
    endtask
    task automatic step(input bit half);
        line_end <= !half;
        half_line <= half;
        @(posedge clk);
        line_end <= 1'b0;
        half_line <= 1'b0;
        @(posedge clk);
    endtask
    task automatic outs(input int c, input bit f, input int be);
        chk("vsync", 32'(c >= 8 && c < 10), 32'(vsync));
        // Blank end line zero means blanking runs to the wrap
        chk("vblank", 32'(c >= 7 && (c < be || be == 0)), 32'(vblank));
        chk("active", 32'(c <= 5), 32'(act));
        chk("field", 32'(f), 32'(field));
    endtask
    initial begin
        logic [31:0] vals [3];
        logic [15:0] adrs [3];
        // Blank and sync lowered by the centering offset
        vals = '{32'hF80D_F805, 32'hF800_F800 | ((13 - OFS) << 16) | (8 - OFS),
            32'hF800_F800 | ((11 - OFS) << 16) | (9 - OFS)};
        adrs = '{OFF_TOTAL_ACTIVE, OFF_BLANK_WINDOW, OFF_SYNC_WINDOW};
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rdr(OFF_TOTAL_ACTIVE, rd, rsp);
        chk("reset value", RST_TIMING, rd);
        for (int k = 0; k < 3; k++) begin
            wr(adrs[k], vals[k], rsp);
            chk("write resp", 32'(RESP_OKAY), 32'(rsp));
            rdr(adrs[k], rd, rsp);
            chk("readback", vals[k] & FIELD_MASK, rd);
        end
        wr(16'h8000, 32'h1, rsp);
        chk("unmapped write", 32'(RESP_SLVERR), 32'(rsp));
        rdr(16'h8000, rd, rsp);
        chk("unmapped read", 32'(RESP_SLVERR), 32'(rsp));
        $display("test registers done");
        wr(OFF_CONTROL, 32'h2, rsp);
        n = 0;
        repeat (28) begin
            step(1'b0);
            n = (n >= 13) ? 0 : n + 1;
            outs(n, 1'b0, 12);
        end
        chk("sync lines", 32'd2, 32'(sync_lines));
        chk("blank lines", 32'd5, 32'(blank_lines));
        rdr(OFF_STATUS, rd, rsp);
        chk("count", 32'(n), 32'(rd[14:4]));
        $display("test progressive done");
        wr(OFF_CONTROL, 32'h0, rsp);
        wr(OFF_TOTAL_ACTIVE, 32'h000C_0005, rsp);
        wr(OFF_BLANK_WINDOW, 32'h000C_0006, rsp);
        wr(OFF_CONTROL, 32'h3, rsp);
        n = 0;
        for (int k = 1; k <= 13; k++) begin
            step(k % 2);
            n = (n >= 12) ? 0 : n + 1;
            outs(n, k == 13, 0);
            if (k == 1) begin
                rdr(OFF_STATUS, rd, rsp);
                chk("half count", 32'h1, 32'(rd[14:4]));
                chk("status flags", 32'h1, 32'(rd[3:0]));
            end
        end
        $display("test interlace done");
        stop_test();
    end
endmodule // vdt_top_tb
bind vdt_top vdt_top_asserts chk_u (.*);
`default_nettype wire

// ### rtl/vdt_counter.sv
`default_nettype none
module vdt_counter #(
    parameter int W = 11
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic run,
    input wire logic step,
    input wire logic [W-1:0] total,
    output logic [W-1:0] cnt,
    output logic [W-1:0] cnt_nxt,
    output logic wrap
);
    // Next line number, wrapping after the total
    always_comb begin
        wrap = step && (cnt >= total);
        if (!run) begin
            cnt_nxt = '0;
        end else if (wrap) begin
            cnt_nxt = '0;
        end else if (step) begin
            cnt_nxt = cnt + W'(1);
        end else begin
            cnt_nxt = cnt;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= '0;
        end else begin
            cnt <= cnt_nxt;
        end
    end
endmodule // vdt_counter
`default_nettype wire

// ### rtl/vdt_pkg.sv
`default_nettype none
package vdt_pkg;
    localparam int LINE_W = 11;
    localparam logic [15:0] OFF_TOTAL_ACTIVE = 16'h8340;
    localparam logic [15:0] OFF_BLANK_WINDOW = 16'h8344;
    localparam logic [15:0] OFF_SYNC_WINDOW = 16'h8348;
    localparam logic [15:0] OFF_CONTROL = 16'h8360;
    localparam logic [15:0] OFF_STATUS = 16'h8364;
    localparam int HI_LSB = 16;
    localparam int LO_LSB = 0;
    localparam int CTL_INTERLACE = 0;
    localparam int CTL_ENABLE = 1;
    localparam logic [31:0] RST_TIMING = 32'h0000_0000;
    localparam logic [31:0] FIELD_MASK = 32'h07FF_07FF;
    localparam logic [31:0] CTL_MASK = 32'h0000_0003;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [LINE_W-1:0] total;
        logic [LINE_W-1:0] active;
        logic [LINE_W-1:0] blank_start;
        logic [LINE_W-1:0] blank_end;
        logic [LINE_W-1:0] sync_start;
        logic [LINE_W-1:0] sync_end;
        logic interlace;
        logic enable;
    } vdt_cfg_t;

    typedef struct packed {
        logic [LINE_W-1:0] count;
        logic vblank;
        logic vsync;
        logic field;
        logic active;
    } vdt_stat_t;
endpackage
`default_nettype wire

// ### rtl/vdt_top.sv
// Functional notes
// - Bits 26:16 of the total/active register hold frame lines minus one, blanking and border included.
// - Bits 10:0 of the total/active register hold displayed lines minus one, with no check against the total.
// - Bits 26:16 of the blank window register give the line where blanking ends, minus one.
// - Vertical sync drops at the line given by bits 26:16 of the sync window register plus one.
// - Vertical sync rises at the line given by bits 10:0 of the sync window register plus one.
// - In interlace mode the counter steps twice per line, so sync starts mid-line in alternate fields.
`default_nettype none
module vdt_top
    import vdt_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic line_end,
    input wire logic half_line,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic vblank_o,
    output logic vsync_o,
    output logic field_o,
    output logic display_active_o
);
    import vdt_pkg::*;

    logic [31:0] total_active_r;
    logic [31:0] blank_window_r;
    logic [31:0] sync_window_r;
    logic [1:0] control_r;
    logic [15:0] aw_addr_r;
    logic aw_held_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic w_held_r;
    vdt_cfg_t cfg;
    vdt_stat_t stat;
    logic step;
    logic [LINE_W-1:0] cnt;
    logic [LINE_W-1:0] cnt_nxt;
    logic wrap;
    logic wr_fire;

    // Line after the field; the line after the total is line zero
    function automatic logic line_hit(input logic [LINE_W-1:0] c, input logic [LINE_W-1:0] f,
                                      input logic [LINE_W-1:0] t);
        if (f == t) begin
            line_hit = (c == '0);
        end else begin
            line_hit = (c == f + LINE_W'(1));
        end
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [31:0] m);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        merge = r & m;
    endfunction

    assign cfg.total = total_active_r[HI_LSB +: LINE_W];
    assign cfg.active = total_active_r[LO_LSB +: LINE_W];
    assign cfg.blank_start = blank_window_r[LO_LSB +: LINE_W];
    assign cfg.blank_end = blank_window_r[HI_LSB +: LINE_W];
    assign cfg.sync_start = sync_window_r[LO_LSB +: LINE_W];
    assign cfg.sync_end = sync_window_r[HI_LSB +: LINE_W];
    assign cfg.interlace = control_r[CTL_INTERLACE];
    assign cfg.enable = control_r[CTL_ENABLE];

    // Two steps per line when interlaced
    assign step = line_end || (cfg.interlace && half_line);

    vdt_counter #(.W(LINE_W)) u_counter (
        .clk(clk),
        .arst_n(arst_n),
        .run(cfg.enable),
        .step(step),
        .total(cfg.total),
        .cnt(cnt),
        .cnt_nxt(cnt_nxt),
        .wrap(wrap)
    );

    // Blanking window
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vblank_o <= 1'b0;
        end else if (!cfg.enable) begin
            vblank_o <= 1'b0;
        end else if (step && line_hit(cnt_nxt, cfg.blank_end, cfg.total)) begin
            vblank_o <= 1'b0;
        end else if (step && line_hit(cnt_nxt, cfg.blank_start, cfg.total)) begin
            vblank_o <= 1'b1;
        end
    end

    // Sync window
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vsync_o <= 1'b0;
        end else if (!cfg.enable) begin
            vsync_o <= 1'b0;
        end else if (step && line_hit(cnt_nxt, cfg.sync_end, cfg.total)) begin
            vsync_o <= 1'b0;
        end else if (step && line_hit(cnt_nxt, cfg.sync_start, cfg.total)) begin
            vsync_o <= 1'b1;
        end
    end

    // Field toggles each pass when interlaced
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            field_o <= 1'b0;
        end else if (!cfg.enable || !cfg.interlace) begin
            field_o <= 1'b0;
        end else if (wrap) begin
            field_o <= ~field_o;
        end
    end

    // Displayed lines run from zero to the active value
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            display_active_o <= 1'b0;
        end else begin
            display_active_o <= cfg.enable && (cnt_nxt <= cfg.active);
        end
    end

    assign stat.count = cnt;
    assign stat.vblank = vblank_o;
    assign stat.vsync = vsync_o;
    assign stat.field = field_o;
    assign stat.active = display_active_o;

    // Write address and data captured in either order
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            if (wr_fire) begin
                aw_held_r <= 1'b0;
            end else if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (!aw_held_r && s_axi_awvalid) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            w_held_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= 1'b0;
            if (wr_fire) begin
                w_held_r <= 1'b0;
            end else if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (!w_held_r && s_axi_wvalid) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Register writes and write response
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            total_active_r <= RST_TIMING;
            blank_window_r <= RST_TIMING;
            sync_window_r <= RST_TIMING;
            control_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= RESP_OKAY;
            case (aw_addr_r & 16'hFFFC)
                OFF_TOTAL_ACTIVE: total_active_r <= merge(total_active_r, w_data_r, w_strb_r, FIELD_MASK);
                OFF_BLANK_WINDOW: blank_window_r <= merge(blank_window_r, w_data_r, w_strb_r, FIELD_MASK);
                OFF_SYNC_WINDOW: sync_window_r <= merge(sync_window_r, w_data_r, w_strb_r, FIELD_MASK);
                OFF_CONTROL: control_r <= 2'(merge({30'h0, control_r}, w_data_r, w_strb_r, CTL_MASK));
                OFF_STATUS: s_axi_bresp <= RESP_OKAY;
                default: s_axi_bresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                case (s_axi_araddr & 16'hFFFC)
                    OFF_TOTAL_ACTIVE: s_axi_rdata <= total_active_r;
                    OFF_BLANK_WINDOW: s_axi_rdata <= blank_window_r;
                    OFF_SYNC_WINDOW: s_axi_rdata <= sync_window_r;
                    OFF_CONTROL: s_axi_rdata <= {30'h0, control_r};
                    OFF_STATUS: s_axi_rdata <= {17'h0, stat};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_arvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // vdt_top
`default_nettype wire
